// ===== floppy_status_pkg.sv
// constants and types shared by the floppy status and handshake block
`default_nettype none
package floppy_status_pkg;
  localparam int CLK_MHZ = 250;
  // status bit positions
  localparam int NOT_READY_BIT = 7;
  localparam int PROTECT_BIT = 6;
  localparam int MARK_TYPE_BIT = 5;
  localparam int MISSING_BIT = 4;
  localparam int CHECKSUM_BIT = 3;
  localparam int OVERRUN_BIT = 2;
  localparam int PENDING_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [1:0] STATUS_ADDR = 2'h0;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // write gate lead and trail, microseconds
  localparam int GATE_FM_US = 4;
  localparam int GATE_MFM_US = 2;
  // write data pulse widths, nanoseconds (the single density figure is 1.38 us)
  localparam int PULSE_EARLY_NS = 820;
  localparam int PULSE_NOMINAL_NS = 690;
  localparam int PULSE_LATE_NS = 570;
  localparam int PULSE_FM_NS = 1380;
  // latest completion interrupt clear after a strobe, microseconds
  localparam int IRQ_CLEAR_US = 8;
  // least master reset pulse kept by the outside party, microseconds
  localparam int MASTER_RESET_MIN_US = 50;
  localparam logic [9:0] GATE_FM_CYC = 10'(GATE_FM_US * CLK_MHZ);
  localparam logic [9:0] GATE_MFM_CYC = 10'(GATE_MFM_US * CLK_MHZ);
  localparam logic [8:0] PULSE_EARLY_CYC = 9'((PULSE_EARLY_NS * CLK_MHZ) / 1000);
  localparam logic [8:0] PULSE_NOMINAL_CYC = 9'((PULSE_NOMINAL_NS * CLK_MHZ) / 1000);
  localparam logic [8:0] PULSE_LATE_CYC = 9'((PULSE_LATE_NS * CLK_MHZ) / 1000);
  localparam logic [8:0] PULSE_FM_CYC = 9'((PULSE_FM_NS * CLK_MHZ) / 1000);
  typedef enum logic [3:0] {
    GATE_IDLE = 4'h1,
    GATE_LEAD = 4'h2,
    GATE_ACTIVE = 4'h4,
    GATE_TRAIL = 4'h8
  } gate_state_type;
endpackage
`default_nettype wire

// ===== floppy_status_host_handshake.sv
// status register, host handshake and write gate sequencing of the floppy controller
`default_nettype none
module floppy_status_host_handshake
  import floppy_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic masterResetN,
  input wire logic csN,
  input wire logic hostFetchStrobeN,
  input wire logic hostStoreStrobeN,
  input wire logic [1:0] regAddr,
  input wire logic driveReady,
  input wire logic writeProtect,
  input wire logic doubleDensity,
  input wire logic cmdStart,
  input wire logic cmdIsWrite,
  input wire logic cmdDone,
  input wire logic recordNotFound,
  input wire logic checksumFault,
  input wire logic deletedMark,
  input wire logic byteReady,
  input wire logic writeStreamOn,
  input wire logic bitPulseReq,
  input wire logic precompEarly,
  input wire logic precompLate,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic byteTransferRequest,
  output logic completionIrq,
  output logic writeGate,
  output logic writeData
);
  typedef struct packed {
    logic notReady;
    logic protect;
    logic markType;
    logic missing;
    logic checksum;
    logic overrun;
    logic pending;
    logic busy;
    logic irq;
    logic isWrite;
    logic csPrevN;
    logic fetchPrevN;
    logic storePrevN;
    gate_state_type gateState;
    logic [9:0] gateCnt;
    logic [8:0] pulseCnt;
    logic gate;
    logic data;
    logic [7:0] dataOut;
    logic dataOe;
  } state_type;

  state_type stateReg;
  state_type stateNext;
  logic [7:0] statusWord;
  logic notReadyNow;
  logic fetchRise;
  logic storeFall;
  logic strobeClear;

  assign statusWord = {stateReg.notReady, stateReg.protect, stateReg.markType,
                       stateReg.missing, stateReg.checksum, stateReg.overrun,
                       stateReg.pending, stateReg.busy};
  assign notReadyNow = ~driveReady | ~masterResetN;
  // the read strobe rise is qualified by the select held in the previous cycle, so a select
  // that releases together with the read strobe still counts; the write strobe fall uses the current select
  assign fetchRise = ~stateReg.fetchPrevN ? hostFetchStrobeN & ~stateReg.csPrevN : 1'b0;
  assign storeFall = stateReg.storePrevN & ~hostStoreStrobeN & ~csN;
  assign strobeClear = fetchRise | storeFall;

  always_comb begin
    stateNext = stateReg;
    stateNext.csPrevN = csN;
    stateNext.fetchPrevN = hostFetchStrobeN;
    stateNext.storePrevN = hostStoreStrobeN;
    stateNext.notReady = notReadyNow;
    if (strobeClear) begin
      stateNext.pending = 1'b0;
      stateNext.irq = 1'b0;
    end
    if (cmdStart && !stateReg.busy) begin
      stateNext.protect = 1'b0;
      stateNext.markType = 1'b0;
      stateNext.missing = 1'b0;
      stateNext.checksum = 1'b0;
      stateNext.overrun = 1'b0;
      stateNext.pending = 1'b0;
      stateNext.irq = 1'b0;
      stateNext.isWrite = cmdIsWrite;
      if (notReadyNow) begin
        stateNext.irq = 1'b1;
      end else if (cmdIsWrite && writeProtect) begin
        stateNext.protect = 1'b1;
        stateNext.irq = 1'b1;
      end else begin
        stateNext.busy = 1'b1;
      end
    end else if (stateReg.busy) begin
      if (recordNotFound) begin
        stateNext.missing = 1'b1;
      end
      if (checksumFault) begin
        stateNext.checksum = 1'b1;
      end
      if (deletedMark && !stateReg.isWrite) begin
        stateNext.markType = 1'b1;
      end
      // a new byte while the last is unserviced is lost
      if (byteReady && stateReg.pending && !strobeClear) begin
        stateNext.overrun = 1'b1;
      end
      // request set wins over a strobe clear
      if (byteReady) begin
        stateNext.pending = 1'b1;
      end
      if (cmdDone) begin
        stateNext.busy = 1'b0;
        stateNext.irq = 1'b1;
      end
    end
    if (stateNext.isWrite) begin
      stateNext.markType = 1'b0;
    end
    // the read path samples status; its strobe rise also clears pending and irq above
    stateNext.dataOe = ~csN & ~hostFetchStrobeN & (regAddr == STATUS_ADDR);
    stateNext.dataOut = stateNext.dataOe ? statusWord : 8'h00;

    unique case (stateReg.gateState)
      GATE_IDLE: begin
        if (stateReg.busy && stateReg.isWrite && writeStreamOn) begin
          stateNext.gate = 1'b1;
          stateNext.gateCnt = (doubleDensity ? GATE_MFM_CYC : GATE_FM_CYC) - 10'h001;
          stateNext.gateState = GATE_LEAD;
        end
      end
      GATE_LEAD: begin
        if (stateReg.gateCnt == 10'h000) begin
          stateNext.gateState = GATE_ACTIVE;
        end else begin
          stateNext.gateCnt = stateReg.gateCnt - 10'h001;
        end
      end
      GATE_ACTIVE: begin
        if (stateReg.pulseCnt != 9'h000) begin
          stateNext.pulseCnt = stateReg.pulseCnt - 9'h001;
          if (stateReg.pulseCnt == 9'h001) begin
            stateNext.data = 1'b0;
          end
        end else if (bitPulseReq) begin
          stateNext.data = 1'b1;
          if (!doubleDensity) begin
            stateNext.pulseCnt = PULSE_FM_CYC;
          end else if (precompEarly) begin
            stateNext.pulseCnt = PULSE_EARLY_CYC;
          end else if (precompLate) begin
            stateNext.pulseCnt = PULSE_LATE_CYC;
          end else begin
            stateNext.pulseCnt = PULSE_NOMINAL_CYC;
          end
        end else if (!writeStreamOn) begin
          stateNext.gateCnt = (doubleDensity ? GATE_MFM_CYC : GATE_FM_CYC) - 10'h001;
          stateNext.gateState = GATE_TRAIL;
        end
      end
      GATE_TRAIL: begin
        if (stateReg.gateCnt == 10'h000) begin
          stateNext.gate = 1'b0;
          stateNext.gateState = GATE_IDLE;
        end else begin
          stateNext.gateCnt = stateReg.gateCnt - 10'h001;
        end
      end
      default: begin
        stateNext.gateState = GATE_IDLE;
        stateNext.gate = 1'b0;
        stateNext.data = 1'b0;
      end
    endcase

    // master reset clears all but not-ready
    if (!masterResetN) begin
      stateNext = '0;
      stateNext.notReady = 1'b1;
      stateNext.csPrevN = 1'b1;
      stateNext.fetchPrevN = 1'b1;
      stateNext.storePrevN = 1'b1;
      stateNext.gateState = GATE_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateReg <= '0;
      stateReg.notReady <= STATUS_RESET[NOT_READY_BIT];
      stateReg.csPrevN <= 1'b1;
      stateReg.fetchPrevN <= 1'b1;
      stateReg.storePrevN <= 1'b1;
      stateReg.gateState <= GATE_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign hostDataOut = stateReg.dataOut;
  assign hostDataOe = stateReg.dataOe;
  // one flop feeds both pin and status bit
  assign byteTransferRequest = stateReg.pending;
  assign completionIrq = stateReg.irq;
  assign writeGate = stateReg.gate;
  assign writeData = stateReg.data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence startReq;
    cmdStart && !stateReg.busy && masterResetN;
  endsequence
  sequence gateRise;
    !stateReg.gate ##1 stateReg.gate;
  endsequence

  // the edge that releases rst still loads the reset value, so skip attempts sampled in reset
  notReadyTrack_a: assert property (!rst |=> statusWord[NOT_READY_BIT] == $past(notReadyNow))
    else $error("not-ready bit does not follow drive ready and master reset");
  refuseStart_a: assert property (startReq and !driveReady |=> !stateReg.busy && completionIrq)
    else $error("command started while drive not ready");
  protectStop_a: assert property (startReq and driveReady && cmdIsWrite && writeProtect
      |=> statusWord[PROTECT_BIT] && !stateReg.busy)
    else $error("protected write did not flag and stop");
  markZero_a: assert property (stateReg.isWrite |-> !statusWord[MARK_TYPE_BIT])
    else $error("mark type set during write");
  missingSet_a: assert property (stateReg.busy && !cmdStart && recordNotFound && masterResetN
      |=> statusWord[MISSING_BIT])
    else $error("record not found not flagged");
  lostByte_a: assert property (stateReg.busy && stateReg.pending && byteReady && !strobeClear
      && masterResetN |=> statusWord[OVERRUN_BIT] && byteTransferRequest)
    else $error("missed byte not flagged as lost");
  fetchClear_a: assert property (stateReg.pending && fetchRise && !byteReady && !cmdStart
      && masterResetN |=> !byteTransferRequest ##0 statusWord[PENDING_BIT] == 1'b0)
    else $error("request not cleared by read strobe rise");
  doneIrq_a: assert property (stateReg.busy && !cmdStart && cmdDone && masterResetN
      |=> !statusWord[BUSY_BIT] && completionIrq)
    else $error("completion did not drop busy and raise interrupt");
  leadGap_a: assert property (gateRise |-> (!writeData && masterResetN)[*8] or
      (!masterResetN ##[0:7] 1'b1))
    else $error("write data too soon after gate");
  trailGap_a: assert property ($fell(writeGate) && masterResetN |-> !$past(writeData, 8))
    else $error("gate released too soon after data");
endmodule // floppy_status_host_handshake
`default_nettype wire

// ===== floppy_host_model.sv
// host processor model driving the status bus strobes
`default_nettype none
module floppy_host_model (
  input wire logic clk,
  output logic csN,
  output logic hostFetchStrobeN,
  output logic hostStoreStrobeN,
  output logic [1:0] regAddr,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csN = 1'b1;
    hostFetchStrobeN = 1'b1;
    hostStoreStrobeN = 1'b1;
    regAddr = 2'h3;
  end
  task automatic fetch(input logic [1:0] a, output logic [7:0] v, output logic oe);
    @(posedge clk);
    csN <= 1'b0;
    hostFetchStrobeN <= 1'b0;
    regAddr <= a;
    @(posedge clk);
    @(negedge clk);
    v = hostDataOut;
    oe = hostDataOe;
    @(posedge clk);
    csN <= 1'b1;
    hostFetchStrobeN <= 1'b1;
    // a deselected bus does not keep the old address
    regAddr <= ~a;
  endtask
  task automatic store();
    @(posedge clk);
    csN <= 1'b0;
    hostStoreStrobeN <= 1'b0;
    @(posedge clk);
    csN <= 1'b1;
    hostStoreStrobeN <= 1'b1;
  endtask
endmodule // floppy_host_model
`default_nettype wire

// ===== test_floppy_status_host_handshake.sv
// self-checking bench for the floppy status and handshake block
`default_nettype none
module test_floppy_status_host_handshake;
  import floppy_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic masterResetN, driveReady, writeProtect, doubleDensity, cmdStart, cmdIsWrite;
  logic cmdDone, recordNotFound, checksumFault, deletedMark, byteReady, writeStreamOn;
  logic bitPulseReq, precompEarly, precompLate, csN, hostFetchStrobeN, hostStoreStrobeN;
  logic hostDataOe, byteTransferRequest, completionIrq, writeGate, writeData;
  logic [1:0] regAddr;
  logic [7:0] hostDataOut;
  int errTotal = 0;
  int cmpCount = 0;
  always #2 clk = ~clk;
  floppy_status_host_handshake DUT (.clk, .rst, .masterResetN, .csN, .hostFetchStrobeN,
    .hostStoreStrobeN, .regAddr, .driveReady, .writeProtect, .doubleDensity, .cmdStart,
    .cmdIsWrite, .cmdDone, .recordNotFound, .checksumFault, .deletedMark, .byteReady,
    .writeStreamOn, .bitPulseReq, .precompEarly, .precompLate, .hostDataOut, .hostDataOe,
    .byteTransferRequest, .completionIrq, .writeGate, .writeData);
  floppy_host_model host (.clk, .csN, .hostFetchStrobeN, .hostStoreStrobeN, .regAddr,
    .hostDataOut, .hostDataOe);
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // timings are nominal, so allow a two cycle slack
  task automatic near(input string nm, input int exp, input int got);
    cmpCount++;
    if (got < exp - 2 || got > exp + 2) begin
      errTotal++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [7:0] v;
    logic oe;
    host.fetch(2'h0, v, oe);
    chk("oe", 10'h1, 10'(oe));
    chk("status", 10'(exp), 10'(v));
    repeat (2) @(posedge clk);
  endtask
  task automatic cmd(input logic w);
    @(posedge clk) begin cmdStart <= 1'b1; cmdIsWrite <= w; end
    @(posedge clk) cmdStart <= 1'b0;
    @(negedge clk);
  endtask
  // bits: done, missing, checksum, deleted, byte
  task automatic ev(input logic [4:0] m);
    @(posedge clk) {cmdDone, recordNotFound, checksumFault, deletedMark, byteReady} <= m;
    @(posedge clk) {cmdDone, recordNotFound, checksumFault, deletedMark, byteReady} <= 5'h0;
    @(negedge clk);
  endtask
  task automatic t_ready();
    rd(8'h00);
    @(posedge clk) driveReady <= 1'b0;
    rd(8'h80);
    cmd(1'b0);
    chk("irq", 10'h1, 10'(completionIrq));
    rd(8'h80);
    @(posedge clk) driveReady <= 1'b1;
    $display("test ready done");
  endtask
  task automatic t_read();
    logic [7:0] v;
    logic oe;
    cmd(1'b0);
    rd(8'h01);
    ev(5'h01);
    chk("request", 10'h1, 10'(byteTransferRequest));
    rd(8'h03);
    chk("request", 10'h0, 10'(byteTransferRequest));
    ev(5'h01);
    ev(5'h01);
    ev(5'h0E);
    rd(8'h3F);
    rd(8'h3D);
    ev(5'h01);
    host.store();
    repeat (2) @(negedge clk);
    chk("request", 10'h0, 10'(byteTransferRequest));
    ev(5'h10);
    chk("irq", 10'h1, 10'(completionIrq));
    rd(8'h3C);
    host.fetch(2'h2, v, oe);
    chk("oe", 10'h0, 10'(oe));
    $display("test read done");
  endtask
  task automatic t_protect();
    @(posedge clk) writeProtect <= 1'b1;
    cmd(1'b1);
    chk("irq", 10'h1, 10'(completionIrq));
    rd(8'h40);
    cmd(1'b1);
    @(posedge clk) begin masterResetN <= 1'b0; writeProtect <= 1'b0; end
    repeat (MASTER_RESET_MIN_US * CLK_MHZ) @(posedge clk);
    masterResetN <= 1'b1;
    @(negedge clk);
    chk("irq", 10'h0, 10'(completionIrq));
    rd(8'h00);
    $display("test protect done");
  endtask
  task automatic t_gate(input logic dd, input logic e, input logic l, input int w);
    int n;
    int lead;
    lead = dd ? int'(GATE_MFM_CYC) : int'(GATE_FM_CYC);
    @(posedge clk) begin doubleDensity <= dd; precompEarly <= e; precompLate <= l; end
    cmd(1'b1);
    @(posedge clk) begin writeStreamOn <= 1'b1; bitPulseReq <= 1'b1; end
    n = 0;
    @(negedge clk);
    while (writeGate !== 1'b1 && n < 9) begin n++; @(negedge clk); end
    n = 0;
    while (writeData !== 1'b1 && n < 2000) begin n++; @(negedge clk); end
    near("lead", lead, n);
    @(posedge clk) begin writeStreamOn <= 1'b0; bitPulseReq <= 1'b0; end
    n = 1;
    @(negedge clk);
    while (writeData === 1'b1 && n < 2000) begin n++; @(negedge clk); end
    chk("width", 10'(w), 10'(n));
    n = 0;
    while (writeGate === 1'b1 && n < 2000) begin n++; @(negedge clk); end
    near("trail", lead, n);
    ev(5'h10);
    $display("test gate done");
  endtask
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {masterResetN, driveReady} = 2'h3;
    {writeProtect, doubleDensity, cmdStart, cmdIsWrite, cmdDone, recordNotFound} = 6'h0;
    {checksumFault, deletedMark, byteReady, writeStreamOn, bitPulseReq} = 5'h0;
    {precompEarly, precompLate} = 2'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_ready();
    t_read();
    t_protect();
    t_gate(1'b1, 1'b0, 1'b0, int'(PULSE_NOMINAL_CYC));
    t_gate(1'b1, 1'b1, 1'b0, int'(PULSE_EARLY_CYC));
    t_gate(1'b1, 1'b0, 1'b1, int'(PULSE_LATE_CYC));
    t_gate(1'b0, 1'b0, 1'b0, int'(PULSE_FM_CYC));
    stopTest();
  end
  initial begin
    #400000;
    errTotal++;
    stopTest();
  end
endmodule // test_floppy_status_host_handshake
`default_nettype wire
